// file: brl_pkg.sv
// Constants and carrier types for the braking resistor duty limiter.
// Assumes a single 250 MHz system clock and settings held by the drive's control logic.
//
// Behaviour
// R1 - The limit mode has two values, reset to 1: 0 drives the resistor freely, 1 applies the duty limit.
// R2 - With limit mode 1 the resistor drive is asserted only within the share of time the duty level allows.
// R3 - The duty level accepts 0 to 30 percent and resets to 10 percent.
// R4 - The duty level is only shown and only takes new values while the limit mode is 1.
// R5 - Continuous braking is cut off after 15 seconds and the drive stays off until the braking request is withdrawn.
// R6 - The duty level is the braking share of one operation cycle, deceleration over the whole cycle times 100.
// R7 - The continuous-braking timer restarts from zero whenever the braking request is withdrawn.
package brl_pkg;

    localparam int BRL_CLK_HZ = 250_000_000;
    localparam int BRL_CONT_LIMIT_SEC = 15;
    localparam logic BRL_MODE_FREE = 1'b0;
    localparam logic BRL_MODE_LIMIT = 1'b1;
    localparam logic BRL_MODE_RESET = BRL_MODE_LIMIT;
    localparam logic [4:0] BRL_DUTY_MAX = 5'h1e;
    localparam logic [4:0] BRL_DUTY_RESET = 5'h0a;
    localparam logic [6:0] BRL_PERCENT_FULL = 7'h64;

    // Settings as written by the drive's parameter logic
    typedef struct packed {
        logic brake_limit_mode;
        logic duty_write;
        logic [4:0] duty_value;
    } brl_cfg_t;

    // Settings as shown back to the parameter display
    typedef struct packed {
        logic brake_limit_mode;
        logic duty_visible;
        logic [4:0] brake_duty_level;
    } brl_view_t;

endpackage

// file: brl_limiter.sv
// Braking resistor duty limiter: gates the dynamic braking drive signal.
// Assumes brake_req_i comes from control logic on clk_sys_i; no synchroniser needed.
`timescale 1ns/100ps

module brl_limiter import brl_pkg::*; #(
    parameter int CYCLE_CLKS = 1000,
    parameter longint CONT_LIMIT_CLKS = longint'(BRL_CONT_LIMIT_SEC) * BRL_CLK_HZ
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire brl_cfg_t cfg_i,
    input wire logic brake_req_i,
    output brl_view_t view_o,
    output logic dynamic_braking_o,
    output logic cont_expired_o
);

    localparam int SLOT_W = 7;
    localparam int DIV_W = $clog2(CYCLE_CLKS + 1);
    localparam int CNT_W = $clog2(CONT_LIMIT_CLKS + 1);

    ////////////////////////////////////////////////////////////////////////////
    // Parameter checks

    if (CYCLE_CLKS < 1) begin : gen_cycle_check
        $error("brl_limiter: CYCLE_CLKS must be at least 1");
    end

    if (CONT_LIMIT_CLKS < 2) begin : gen_limit_check
        $error("brl_limiter: CONT_LIMIT_CLKS must be at least 2");
    end

    // The slot counter must hold every slot of one operation cycle
    if ((1 << SLOT_W) <= BRL_PERCENT_FULL) begin : gen_slot_check
        $error("brl_limiter: SLOT_W too narrow for the cycle slots");
    end

    if (BRL_DUTY_MAX >= BRL_PERCENT_FULL) begin : gen_duty_check
        $error("brl_limiter: duty maximum must be below a full cycle");
    end

    logic mode_reg;
    logic [4:0] duty_reg;
    logic [4:0] duty_next;
    logic [4:0] view_level_reg;
    logic [DIV_W-1:0] div_reg;
    logic [SLOT_W-1:0] slot_reg;
    logic [CNT_W-1:0] cont_reg;
    logic expired_reg;
    logic drive_reg;
    logic duty_allow;
    logic drive_next;

    ////////////////////////////////////////////////////////////////////////////
    // Settings

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_reg <= BRL_MODE_RESET; // [R1]
        end else begin
            mode_reg <= cfg_i.brake_limit_mode; // [R1]
        end
    end

    // Writes count only while the registered mode is limit; out-of-range values are dropped
    always_comb begin
        duty_next = duty_reg;
        if (cfg_i.duty_write && mode_reg == BRL_MODE_LIMIT && cfg_i.duty_value <= BRL_DUTY_MAX) begin
            duty_next = cfg_i.duty_value; // [R3] [R4]
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            duty_reg <= BRL_DUTY_RESET; // [R3]
        end else begin
            duty_reg <= duty_next;
        end
    end

    // Shown level is built from the next mode and duty so it lines up with mode_reg
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            view_level_reg <= BRL_DUTY_RESET; // [R3]
        end else if (cfg_i.brake_limit_mode == BRL_MODE_LIMIT) begin
            view_level_reg <= duty_next; // [R4]
        end else begin
            view_level_reg <= 5'h00; // [R4]
        end
    end

    assign view_o = {mode_reg, (mode_reg == BRL_MODE_LIMIT), view_level_reg}; // [R4]

    ////////////////////////////////////////////////////////////////////////////
    // Operation cycle split into 100 slots; braking allowed in the first duty slots

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_reg <= '0;
            slot_reg <= '0;
        end else if (div_reg == DIV_W'(CYCLE_CLKS - 1)) begin
            div_reg <= '0;
            slot_reg <= (slot_reg == BRL_PERCENT_FULL - 7'h01) ? 7'h00 : slot_reg + 7'h01; // [R6]
        end else begin
            div_reg <= div_reg + DIV_W'(1);
        end
    end

    assign duty_allow = (slot_reg < {2'b00, duty_reg}); // [R2] [R6]

    ////////////////////////////////////////////////////////////////////////////
    // Continuous braking timer

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cont_reg <= '0;
            expired_reg <= 1'b0;
        end else if (!brake_req_i) begin
            cont_reg <= '0; // [R7]
            expired_reg <= 1'b0; // [R7]
        end else if (cont_reg == CNT_W'(CONT_LIMIT_CLKS - 1)) begin
            expired_reg <= 1'b1; // [R5]
        end else begin
            cont_reg <= cont_reg + CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Drive output

    always_comb begin
        drive_next = brake_req_i && !expired_reg && !(cont_reg == CNT_W'(CONT_LIMIT_CLKS - 1)); // [R5]
        if (mode_reg == BRL_MODE_LIMIT) begin
            drive_next = drive_next && duty_allow; // [R2]
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            drive_reg <= 1'b0;
        end else begin
            drive_reg <= drive_next;
        end
    end

    assign dynamic_braking_o = drive_reg;
    assign cont_expired_o = expired_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    no_req_off_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R7]
        !brake_req_i |=> !dynamic_braking_o && cont_reg == '0)
        else $error("drive or timer active after request withdrawn");

    expired_off_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R5]
        expired_reg |-> !dynamic_braking_o)
        else $error("drive active after continuous limit");

    limit_duty_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R2]
        $past(mode_reg) && $past(slot_reg) >= {2'b00, $past(duty_reg)} |-> !dynamic_braking_o)
        else $error("drive outside duty window");

    free_mode_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R1]
        !mode_reg && brake_req_i && !expired_reg && cont_reg < CNT_W'(CONT_LIMIT_CLKS - 1) |=> dynamic_braking_o)
        else $error("free mode did not drive");

    duty_range_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R3]
        duty_reg <= BRL_DUTY_MAX)
        else $error("duty level out of range");

    duty_hold_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R4]
        !mode_reg |=> $stable(duty_reg))
        else $error("duty level changed in free mode");

    slot_wrap_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R6]
        slot_reg < BRL_PERCENT_FULL)
        else $error("cycle slot out of range");

    expire_set_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R5]
        brake_req_i && cont_reg == CNT_W'(CONT_LIMIT_CLKS - 1) |=> expired_reg || !brake_req_i)
        else $error("continuous limit not flagged");

    drive_needs_req_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R1]
        dynamic_braking_o |-> $past(brake_req_i))
        else $error("drive active without a request");

    hidden_level_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R4]
        !mode_reg |-> view_o.brake_duty_level == 5'h00 && !view_o.duty_visible)
        else $error("duty level shown in free mode");

    shown_level_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R4]
        mode_reg |-> view_o.duty_visible && view_o.brake_duty_level == duty_reg)
        else $error("duty level not shown in limit mode");

    duty_take_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R3]
        cfg_i.duty_write && mode_reg && cfg_i.duty_value <= BRL_DUTY_MAX |=> duty_reg == $past(cfg_i.duty_value))
        else $error("valid duty write not taken");

    duty_refuse_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R3]
        cfg_i.duty_value > BRL_DUTY_MAX |=> $stable(duty_reg))
        else $error("out of range duty taken");

    timer_step_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R5]
        brake_req_i && cont_reg != CNT_W'(CONT_LIMIT_CLKS - 1) |=> cont_reg == $past(cont_reg) + CNT_W'(1))
        else $error("braking timer did not advance");

    expired_hold_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R5]
        expired_reg && brake_req_i |=> expired_reg)
        else $error("continuous limit released while request held");

    expired_clear_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R7]
        !brake_req_i |=> !cont_expired_o)
        else $error("limit flag kept after request withdrawn");

    limit_allow_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R2]
        mode_reg && brake_req_i && !expired_reg && cont_reg < CNT_W'(CONT_LIMIT_CLKS - 1)
        && slot_reg < {2'b00, duty_reg} |=> dynamic_braking_o)
        else $error("drive missing inside duty window");

    div_range_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R6]
        div_reg <= DIV_W'(CYCLE_CLKS - 1))
        else $error("slot divider out of range");

    slot_step_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R6]
        div_reg != DIV_W'(CYCLE_CLKS - 1) |=> $stable(slot_reg))
        else $error("slot moved before divider wrapped");

endmodule

// file: brl_resistor_model.sv
// Resistor switching stage model: counts the cycles in which the drive is on.
// Assumes the drive is sampled on the system clock.
`timescale 1ns/100ps
module brl_resistor_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    input wire logic drive_i,
    output int on_count_o
);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            on_count_o <= 0;
        end else if (clr_i) begin
            on_count_o <= 0;
        end else if (drive_i) begin
            on_count_o <= on_count_o + 1;
        end
    end
endmodule

// file: brl_limiter_bench.sv
// Bench for the duty limiter with short counts: 2-clock slots, 300-clock limit.
// Assumes the resistor model sits on dynamic_braking_o.
`timescale 1ns/100ps
`define CHK(a, b) compares++; if ((a) !== (b)) begin errors++; $display("unexpected %0t bad value", $time); end
module brl_limiter_bench;
    import brl_pkg::*;
    localparam int LIMIT = 300;
    logic clk_sys_i = 0, sys_rst_i = 1, brake_req_i = 0, clr = 0, drv, expd;
    brl_cfg_t cfg_i = {1'b1, 1'b0, 5'h00};
    brl_view_t view_o;
    int errors = 0, compares = 0, on_cnt, n, base;
    always #2 clk_sys_i = ~clk_sys_i;
    brl_limiter #(.CYCLE_CLKS(2), .CONT_LIMIT_CLKS(LIMIT)) brl_limiter_inst (.clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i), .cfg_i(cfg_i), .brake_req_i(brake_req_i), .view_o(view_o),
        .dynamic_braking_o(drv), .cont_expired_o(expd));
    brl_resistor_model brl_resistor_model_inst (.clk_i(clk_sys_i), .rst_i(sys_rst_i), .clr_i(clr),
        .drive_i(drv), .on_count_o(on_cnt));
    task report_and_stop;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task step(input logic m, input logic w, input logic [4:0] v, input logic r);
        @(posedge clk_sys_i);
        cfg_i <= {m, w, v};
        brake_req_i <= r;
        @(posedge clk_sys_i);
        cfg_i.duty_write <= 1'b0;
        #1;
    endtask
    task t_settings;
        `CHK(view_o, ({1'b1, 1'b1, 5'h0a}))
        step(1'b1, 1'b1, 5'h1e, 1'b0);
        `CHK(view_o.brake_duty_level, 5'h1e)
        step(1'b1, 1'b1, 5'h1f, 1'b0);
        `CHK(view_o.brake_duty_level, 5'h1e)
        step(1'b0, 1'b0, 5'h00, 1'b0);
        `CHK(view_o, ({1'b0, 1'b0, 5'h00}))
        step(1'b0, 1'b1, 5'h05, 1'b0);
        `CHK(view_o, ({1'b0, 1'b0, 5'h00}))
        step(1'b1, 1'b0, 5'h00, 1'b0);
        `CHK(view_o.brake_duty_level, 5'h1e)
        $display("settings done");
    endtask
    task t_free;
        step(1'b0, 1'b0, 5'h00, 1'b0);
        base = on_cnt;
        step(1'b0, 1'b0, 5'h00, 1'b1);
        `CHK(drv, 1'b1)
        n = 0;
        while (expd !== 1'b1) begin
            n++;
            if (n > 2 * LIMIT) begin
                errors++;
                report_and_stop();
            end
            @(posedge clk_sys_i);
            #1;
        end
        `CHK(drv, 1'b0)
        `CHK(n, LIMIT - 1)
        `CHK(on_cnt - base, LIMIT - 1)
        step(1'b0, 1'b0, 5'h00, 1'b0);
        `CHK(expd, 1'b0)
        `CHK(drv, 1'b0)
        step(1'b0, 1'b0, 5'h00, 1'b1);
        `CHK(drv, 1'b1)
        $display("free done");
    endtask
    task t_limit;
        step(1'b1, 1'b0, 5'h00, 1'b0);
        step(1'b1, 1'b1, 5'h0a, 1'b0);
        `CHK(view_o.brake_duty_level, 5'h0a)
        step(1'b1, 1'b0, 5'h00, 1'b1);
        clr <= 1'b1;
        @(posedge clk_sys_i);
        clr <= 1'b0;
        repeat (200) @(posedge clk_sys_i);
        #1;
        `CHK(on_cnt, 20)
        `CHK(expd, 1'b0)
        $display("limit done");
    endtask
    initial begin
        repeat (5) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        #1;
        t_settings();
        t_free();
        t_limit();
        report_and_stop();
    end
endmodule
